// ===== common/spsc_pkg.sv
`default_nettype none
package spsc_pkg;
  // status word offsets of the second port
  localparam logic [7:0] OFF_RX_STATE = 8'hdc;
  localparam logic [7:0] OFF_RX_CHARS = 8'hdd;
  localparam logic [7:0] OFF_RX_BLOCKS = 8'hde;
  localparam logic [7:0] OFF_TX_STATE = 8'hdf;
  localparam logic [7:0] OFF_TX_CHARS = 8'he0;
  localparam logic [7:0] OFF_TX_BLOCKS = 8'he1;
  localparam logic [7:0] OFF_FAULTS = 8'he2;
  // fault bit positions
  localparam int BIT_TERM_TYPE = 0;
  localparam int BIT_BAUD = 1;
  localparam int BIT_PARITY = 2;
  localparam int BIT_CHAR_WIDTH = 3;
  localparam int BIT_STOP = 4;
  localparam int BIT_HANDSHAKE = 5;
  localparam int BIT_TERM_COUNT = 6;
  localparam int BIT_PKT_LEN = 7;
  localparam int BIT_RX_TIMEOUT = 8;
  localparam int BIT_CHAR_DELAY = 9;
  localparam int BIT_WR_TIMEOUT = 10;
  localparam int BIT_RX_LOST = 15;
  // limits and substitutes
  localparam logic [15:0] TERM_TYPE_MAX = 16'h000f;
  localparam logic [15:0] TERM_TYPE_DEF = 16'h0000;
  localparam logic [2:0] PARITY_MAX = 3'h4;
  localparam logic [2:0] PARITY_DEF = 3'h0;
  localparam logic [3:0] CHAR_WIDTH_MIN = 4'h5;
  localparam logic [3:0] CHAR_WIDTH_MAX = 4'h8;
  localparam logic [3:0] CHAR_WIDTH_DEF = 4'h8;
  localparam logic [1:0] STOP_DEF = 2'h1;
  localparam logic [1:0] STOP_ALT = 2'h2;
  localparam logic [1:0] HANDSHAKE_DEF = 2'h0;
  localparam logic [15:0] HANDSHAKE_MAX = 16'h0003;
  localparam logic [15:0] TERM_COUNT_MAX = 16'h000c;
  localparam logic [15:0] PKT_LEN_MAX = 16'h1000;
  localparam logic [15:0] WR_TIMEOUT_DEF_MS = 16'h1388;
  localparam logic [3:0] BAUD_CODE_DEF = 4'h5;
  localparam logic [3:0] BAUD_CODE_MAX = 4'h9;
  // termination type codes used for the enable bits
  localparam logic [15:0] TERM_TYPE_STRING_BIT = 16'h0001;
  localparam logic [15:0] TERM_TYPE_PACKET_BIT = 16'h0002;
  // receive and transmit state codes
  localparam logic [15:0] RX_LISTEN = 16'hffff;
  localparam logic [15:0] RX_RECEIVING = 16'h0001;
  localparam logic [15:0] RX_WAIT_XFER = 16'h0002;
  typedef enum logic [15:0] {
    TX_IDLE = 16'h0000,
    TX_RTS_ON = 16'h0001,
    TX_RTS_TIMEOUT = 16'h0002,
    TX_SENDING = 16'h0003,
    TX_WAIT_RTS_OFF = 16'h0004,
    TX_RTS_OFF = 16'h0005,
    TX_CHAR_DLY0 = 16'h001e,
    TX_CHAR_DLY1 = 16'h001f,
    TX_CHAR_DLY2 = 16'h0020,
    TX_MSG_DLY0 = 16'h0064,
    TX_MSG_DLY1 = 16'h0065
  } spsc_tx_state_t;
  localparam logic [15:0] CNT_RESET = 16'h0000;
endpackage
`default_nettype wire

// ===== core/spsc_cfg_check.sv
`timescale 1ns/1ps
`default_nettype none
module spsc_cfg_check
  import spsc_pkg::*;
(
  // raw settings
  input wire logic [15:0] term_type,
  input wire logic [3:0] baud_code,
  input wire logic [2:0] parity,
  input wire logic [3:0] char_width,
  input wire logic [1:0] stop_bits,
  input wire logic [15:0] handshake,
  input wire logic [15:0] term_count,
  input wire logic [15:0] packet_len,
  input wire logic [15:0] rx_timeout,
  input wire logic [15:0] char_delay,
  input wire logic [15:0] wr_timeout,
  // checked settings
  output logic [10:0] cfg_faults,
  output logic [15:0] eff_term_type,
  output logic [3:0] eff_baud,
  output logic [2:0] eff_parity,
  output logic [3:0] eff_char_width,
  output logic [1:0] eff_stop_bits,
  output logic [1:0] eff_handshake,
  output logic use_term_string,
  output logic use_packet_len,
  output logic use_rx_timeout,
  output logic use_char_delay,
  output logic [15:0] eff_wr_timeout
);
  logic string_sel;
  logic packet_sel;
  always_comb begin
    cfg_faults = '0;
    cfg_faults[BIT_TERM_TYPE] = term_type > TERM_TYPE_MAX;
    eff_term_type = cfg_faults[BIT_TERM_TYPE] ? TERM_TYPE_DEF : term_type;
    cfg_faults[BIT_BAUD] = baud_code > BAUD_CODE_MAX;
    eff_baud = cfg_faults[BIT_BAUD] ? BAUD_CODE_DEF : baud_code;
    cfg_faults[BIT_PARITY] = parity > PARITY_MAX;
    eff_parity = cfg_faults[BIT_PARITY] ? PARITY_DEF : parity;
    cfg_faults[BIT_CHAR_WIDTH] = (char_width < CHAR_WIDTH_MIN) ||
                                 (char_width > CHAR_WIDTH_MAX);
    eff_char_width = cfg_faults[BIT_CHAR_WIDTH] ? CHAR_WIDTH_DEF : char_width;
    cfg_faults[BIT_STOP] = (stop_bits != STOP_DEF) && (stop_bits != STOP_ALT);
    eff_stop_bits = cfg_faults[BIT_STOP] ? STOP_DEF : stop_bits;
    cfg_faults[BIT_HANDSHAKE] = handshake > HANDSHAKE_MAX;
    eff_handshake = cfg_faults[BIT_HANDSHAKE] ? HANDSHAKE_DEF : handshake[1:0];
    // termination options follow the substituted type
    string_sel = |(eff_term_type & TERM_TYPE_STRING_BIT);
    packet_sel = |(eff_term_type & TERM_TYPE_PACKET_BIT);
    cfg_faults[BIT_TERM_COUNT] = string_sel &&
        ((term_count == CNT_RESET) || (term_count > TERM_COUNT_MAX));
    use_term_string = string_sel && !cfg_faults[BIT_TERM_COUNT];
    cfg_faults[BIT_PKT_LEN] = packet_sel &&
        ((packet_len == CNT_RESET) || (packet_len > PKT_LEN_MAX));
    use_packet_len = packet_sel && !cfg_faults[BIT_PKT_LEN];
    cfg_faults[BIT_RX_TIMEOUT] = rx_timeout == CNT_RESET;
    use_rx_timeout = !cfg_faults[BIT_RX_TIMEOUT];
    cfg_faults[BIT_CHAR_DELAY] = char_delay == CNT_RESET;
    use_char_delay = !cfg_faults[BIT_CHAR_DELAY];
    cfg_faults[BIT_WR_TIMEOUT] = wr_timeout == CNT_RESET;
    eff_wr_timeout = cfg_faults[BIT_WR_TIMEOUT] ? WR_TIMEOUT_DEF_MS : wr_timeout;
  end
endmodule
`default_nettype wire

// ===== core/spsc_status_mem.sv
`timescale 1ns/1ps
`default_nettype none
module spsc_status_mem
  import spsc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // live status words
  input wire logic [15:0] words [7],
  // read port
  input wire logic [7:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] rd_data_d;
  logic [15:0] rd_data_q;
  always_comb begin
    case (rd_addr)
      OFF_RX_STATE: rd_data_d = words[0];
      OFF_RX_CHARS: rd_data_d = words[1];
      OFF_RX_BLOCKS: rd_data_d = words[2];
      OFF_TX_STATE: rd_data_d = words[3];
      OFF_TX_CHARS: rd_data_d = words[4];
      OFF_TX_BLOCKS: rd_data_d = words[5];
      OFF_FAULTS: rd_data_d = words[6];
      default: rd_data_d = CNT_RESET;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rd_data_q <= CNT_RESET;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end
  assign rd_data = rd_data_q;
endmodule
`default_nettype wire

// ===== core/spsc_port_status.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - receive state reads -1 listening, 1 receiving, 2 awaiting backplane transfer
// - transmit state codes 0 to 5 cover idle, rts, send and release
// - codes 30 to 32 mark intercharacter delay, 100 and 101 message delay
// - received characters at word 221, received blocks at word 222
// - transmitted characters at word 224, transmitted blocks at word 225
// - one bit-mapped fault word at word 226
// - termination type above 15 flags bit 0, stream mode used
// - invalid baud flags bit 1, 9600 baud used
// - parity above 4 flags bit 2, no parity used
// - data bits outside 5 to 8 flag bit 3, eight used
// - stop bits not 1 or 2 flag bit 4, one used
// - handshake above 3 flags bit 5, no handshake used
// - bad terminator count with string ending flags bit 6, string ending off
// - bad packet length with packet ending flags bit 7, packet ending off
// - zero receive timeout flags bit 8, timeout ending off
// - zero intercharacter delay flags bit 9, delay option off
// - zero write timeout flags bit 10, 5000 ms used
// - data arriving while a block awaits transfer flags bit 15, data dropped
module spsc_port_status
  import spsc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // configuration load
  input wire logic cfg_load,
  input wire logic [15:0] term_type,
  input wire logic [3:0] baud_code,
  input wire logic [2:0] parity,
  input wire logic [3:0] char_width,
  input wire logic [1:0] stop_bits,
  input wire logic [15:0] handshake,
  input wire logic [15:0] term_count,
  input wire logic [15:0] packet_len,
  input wire logic [15:0] rx_timeout,
  input wire logic [15:0] char_delay,
  input wire logic [15:0] wr_timeout,
  // receive events
  input wire logic rx_char,
  input wire logic rx_block_done,
  input wire logic rx_block_taken,
  // transmit events
  input wire logic tx_start,
  input wire logic tx_rts_ok,
  input wire logic tx_rts_expired,
  input wire logic tx_char,
  input wire logic tx_char_gap,
  input wire logic tx_last_char,
  input wire logic tx_rts_released,
  input wire logic msg_delay_on,
  // status read
  input wire logic [7:0] rd_addr,
  input wire logic lost_clear,
  output logic [15:0] rd_data,
  // effective settings
  output logic [15:0] eff_term_type,
  output logic [3:0] eff_baud,
  output logic [2:0] eff_parity,
  output logic [3:0] eff_char_width,
  output logic [1:0] eff_stop_bits,
  output logic [1:0] eff_handshake,
  output logic use_term_string,
  output logic use_packet_len,
  output logic use_rx_timeout,
  output logic use_char_delay,
  output logic [15:0] eff_wr_timeout,
  output logic rx_drop
);

  // ------------------------------------------------------------
  // configuration check
  // ------------------------------------------------------------
  logic [10:0] chk_faults;
  logic [15:0] c_term_type;
  logic [3:0] c_baud;
  logic [2:0] c_parity;
  logic [3:0] c_char_width;
  logic [1:0] c_stop;
  logic [1:0] c_handshake;
  logic c_use_string;
  logic c_use_packet;
  logic c_use_rx_to;
  logic c_use_delay;
  logic [15:0] c_wr_timeout;

  spsc_cfg_check u_check (
    .term_type(term_type),
    .baud_code(baud_code),
    .parity(parity),
    .char_width(char_width),
    .stop_bits(stop_bits),
    .handshake(handshake),
    .term_count(term_count),
    .packet_len(packet_len),
    .rx_timeout(rx_timeout),
    .char_delay(char_delay),
    .wr_timeout(wr_timeout),
    .cfg_faults(chk_faults),
    .eff_term_type(c_term_type),
    .eff_baud(c_baud),
    .eff_parity(c_parity),
    .eff_char_width(c_char_width),
    .eff_stop_bits(c_stop),
    .eff_handshake(c_handshake),
    .use_term_string(c_use_string),
    .use_packet_len(c_use_packet),
    .use_rx_timeout(c_use_rx_to),
    .use_char_delay(c_use_delay),
    .eff_wr_timeout(c_wr_timeout)
  );

  logic [10:0] cfg_faults_q, cfg_faults_d;
  logic [15:0] term_type_q, term_type_d;
  logic [3:0] baud_q, baud_d;
  logic [2:0] parity_q, parity_d;
  logic [3:0] width_q, width_d;
  logic [1:0] stop_q, stop_d;
  logic [1:0] hs_q, hs_d;
  logic [3:0] opts_q, opts_d;
  logic [15:0] wr_to_q, wr_to_d;

  // settings are latched so they stay steady between loads
  always_comb begin
    cfg_faults_d = cfg_faults_q;
    term_type_d = term_type_q;
    baud_d = baud_q;
    parity_d = parity_q;
    width_d = width_q;
    stop_d = stop_q;
    hs_d = hs_q;
    opts_d = opts_q;
    wr_to_d = wr_to_q;
    if (cfg_load) begin
      cfg_faults_d = chk_faults;
      term_type_d = c_term_type;
      baud_d = c_baud;
      parity_d = c_parity;
      width_d = c_char_width;
      stop_d = c_stop;
      hs_d = c_handshake;
      opts_d = {c_use_string, c_use_packet, c_use_rx_to, c_use_delay};
      wr_to_d = c_wr_timeout;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg_faults_q <= '0;
      term_type_q <= TERM_TYPE_DEF;
      baud_q <= BAUD_CODE_DEF;
      parity_q <= PARITY_DEF;
      width_q <= CHAR_WIDTH_DEF;
      stop_q <= STOP_DEF;
      hs_q <= HANDSHAKE_DEF;
      opts_q <= '0;
      wr_to_q <= WR_TIMEOUT_DEF_MS;
    end else begin
      cfg_faults_q <= cfg_faults_d;
      term_type_q <= term_type_d;
      baud_q <= baud_d;
      parity_q <= parity_d;
      width_q <= width_d;
      stop_q <= stop_d;
      hs_q <= hs_d;
      opts_q <= opts_d;
      wr_to_q <= wr_to_d;
    end
  end

  assign eff_term_type = term_type_q;
  assign eff_baud = baud_q;
  assign eff_parity = parity_q;
  assign eff_char_width = width_q;
  assign eff_stop_bits = stop_q;
  assign eff_handshake = hs_q;
  assign use_term_string = opts_q[3];
  assign use_packet_len = opts_q[2];
  assign use_rx_timeout = opts_q[1];
  assign use_char_delay = opts_q[0];
  assign eff_wr_timeout = wr_to_q;

  // ------------------------------------------------------------
  // receive side
  // ------------------------------------------------------------
  logic [15:0] rx_state_q, rx_state_d;
  logic [15:0] rx_chars_q, rx_chars_d;
  logic [15:0] rx_blocks_q, rx_blocks_d;
  logic rx_lost_q, rx_lost_d;
  logic rx_drop_q, rx_drop_d;

  always_comb begin
    rx_state_d = rx_state_q;
    rx_chars_d = rx_chars_q;
    rx_blocks_d = rx_blocks_q;
    rx_lost_d = rx_lost_q;
    rx_drop_d = 1'b0;
    // a new block only forms once the held one has gone to the host
    if (rx_state_q == RX_WAIT_XFER) begin
      if (rx_char) begin
        rx_drop_d = 1'b1;
      end
      if (rx_block_taken) begin
        rx_state_d = RX_LISTEN;
      end
    end else if (rx_block_done) begin
      rx_state_d = RX_WAIT_XFER;
      rx_blocks_d = rx_blocks_q + 16'h0001;
    end else if (rx_char) begin
      rx_state_d = RX_RECEIVING;
    end
    if (rx_char && !rx_drop_d) begin
      rx_chars_d = rx_chars_q + 16'h0001;
    end
    // set wins over clear, so a drop in the clearing cycle is kept
    if (lost_clear) begin
      rx_lost_d = 1'b0;
    end
    if (rx_drop_d) begin
      rx_lost_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_state_q <= RX_LISTEN;
      rx_chars_q <= CNT_RESET;
      rx_blocks_q <= CNT_RESET;
      rx_lost_q <= 1'b0;
      rx_drop_q <= 1'b0;
    end else begin
      rx_state_q <= rx_state_d;
      rx_chars_q <= rx_chars_d;
      rx_blocks_q <= rx_blocks_d;
      rx_lost_q <= rx_lost_d;
      rx_drop_q <= rx_drop_d;
    end
  end

  assign rx_drop = rx_drop_q;

  // ------------------------------------------------------------
  // transmit side
  // ------------------------------------------------------------
  spsc_tx_state_t tx_state_q, tx_state_d;
  logic [15:0] tx_chars_q, tx_chars_d;
  logic [15:0] tx_blocks_q, tx_blocks_d;

  always_comb begin
    tx_state_d = tx_state_q;
    tx_chars_d = tx_chars_q;
    tx_blocks_d = tx_blocks_q;
    case (tx_state_q)
      TX_IDLE: begin
        if (tx_start) begin
          tx_state_d = msg_delay_on ? TX_MSG_DLY0 : TX_RTS_ON;
        end
      end
      TX_MSG_DLY0: tx_state_d = TX_MSG_DLY1;
      TX_MSG_DLY1: begin
        if (!msg_delay_on) begin
          tx_state_d = TX_RTS_ON;
        end
      end
      TX_RTS_ON: begin
        if (tx_rts_ok) begin
          tx_state_d = TX_SENDING;
        end else if (tx_rts_expired) begin
          tx_state_d = TX_RTS_TIMEOUT;
        end
      end
      TX_RTS_TIMEOUT: tx_state_d = TX_IDLE;
      TX_SENDING: begin
        if (tx_char) begin
          tx_chars_d = tx_chars_q + 16'h0001;
          if (tx_last_char) begin
            tx_blocks_d = tx_blocks_q + 16'h0001;
            tx_state_d = TX_WAIT_RTS_OFF;
          end else if (tx_char_gap && use_char_delay) begin
            tx_state_d = TX_CHAR_DLY0;
          end
        end
      end
      TX_CHAR_DLY0: tx_state_d = TX_CHAR_DLY1;
      TX_CHAR_DLY1: tx_state_d = TX_CHAR_DLY2;
      TX_CHAR_DLY2: tx_state_d = TX_SENDING;
      TX_WAIT_RTS_OFF: begin
        if (tx_rts_released) begin
          tx_state_d = TX_RTS_OFF;
        end
      end
      TX_RTS_OFF: tx_state_d = TX_IDLE;
      default: tx_state_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_state_q <= TX_IDLE;
      tx_chars_q <= CNT_RESET;
      tx_blocks_q <= CNT_RESET;
    end else begin
      tx_state_q <= tx_state_d;
      tx_chars_q <= tx_chars_d;
      tx_blocks_q <= tx_blocks_d;
    end
  end

  // ------------------------------------------------------------
  // status words
  // ------------------------------------------------------------
  logic [15:0] words [7];
  logic [15:0] fault_word;

  always_comb begin
    fault_word = '0;
    fault_word[10:0] = cfg_faults_q;
    fault_word[BIT_RX_LOST] = rx_lost_q;
  end

  assign words[0] = rx_state_q;
  assign words[1] = rx_chars_q;
  assign words[2] = rx_blocks_q;
  assign words[3] = tx_state_q;
  assign words[4] = tx_chars_q;
  assign words[5] = tx_blocks_q;
  assign words[6] = fault_word;

  spsc_status_mem u_mem (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .words(words),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );
endmodule
`default_nettype wire

// ===== tb/spsc_port_status_sva.sv
`timescale 1ns/1ps
`default_nettype none
module spsc_port_status_chk
  import spsc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // settings
  input wire logic cfg_load,
  input wire logic [15:0] term_type,
  input wire logic [3:0] baud_code,
  input wire logic [3:0] char_width,
  input wire logic [1:0] stop_bits,
  input wire logic [15:0] wr_timeout,
  // status and results
  input wire logic [7:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic rx_drop,
  input wire logic [15:0] eff_term_type,
  input wire logic [3:0] eff_baud,
  input wire logic [3:0] eff_char_width,
  input wire logic [1:0] eff_stop_bits,
  input wire logic [15:0] eff_wr_timeout
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // fallbacks on a bad setting, and a valid baud code kept
  // ----------------------------------------
  a_term_fallback: assert property (
    cfg_load && term_type > 16'h000f |=> eff_term_type == 16'h0000)
    else $error("bad termination type not replaced");
  a_baud_fallback: assert property (
    cfg_load && baud_code > 4'h9 |=> eff_baud == 4'h5)
    else $error("bad baud code not replaced");
  a_baud_passes: assert property (
    cfg_load && baud_code <= 4'h9 |=> eff_baud == $past(baud_code))
    else $error("valid baud code not kept");
  a_width_fallback: assert property (
    cfg_load && (char_width < 4'h5 || char_width > 4'h8) |=> eff_char_width == 4'h8)
    else $error("bad character width not replaced");
  a_stop_fallback: assert property (
    cfg_load && stop_bits != 2'h1 && stop_bits != 2'h2 |=> eff_stop_bits == 2'h1)
    else $error("bad stop bit count not replaced");
  a_write_fallback: assert property (
    cfg_load && wr_timeout == 16'h0000 |=> eff_wr_timeout == 16'h1388)
    else $error("zero write timeout not replaced");

  // ----------------------------------------
  // fault word and setting stability
  // ----------------------------------------
  a_lost_flag: assert property (
    rx_drop && rd_addr == OFF_FAULTS |=> rd_data[15])
    else $error("dropped data not flagged");
  a_spare_bits_zero: assert property (
    rd_addr == OFF_FAULTS |=> rd_data[14:11] == 4'h0)
    else $error("spare fault bits not zero");
  a_settings_hold: assert property (
    !cfg_load |=> $stable(eff_baud) && $stable(eff_wr_timeout))
    else $error("settings changed without a load");
endmodule

bind spsc_port_status spsc_port_status_chk u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .cfg_load(cfg_load), .term_type(term_type),
  .baud_code(baud_code), .char_width(char_width), .stop_bits(stop_bits),
  .wr_timeout(wr_timeout), .rd_addr(rd_addr), .rd_data(rd_data), .rx_drop(rx_drop),
  .eff_term_type(eff_term_type), .eff_baud(eff_baud), .eff_char_width(eff_char_width),
  .eff_stop_bits(eff_stop_bits), .eff_wr_timeout(eff_wr_timeout)
);
`default_nettype wire

// ===== tb/spsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: fetches status words and acknowledges blocks
module spsc_host_model (
  // clock
  input wire logic ref_clk,
  // status read
  input wire logic [15:0] rd_data,
  output logic [7:0] rd_addr,
  output logic rx_block_taken,
  output logic lost_clear
);
  initial begin
    rd_addr = 8'he2;
    rx_block_taken = 1'b0;
    lost_clear = 1'b0;
  end

  // address is left parked so the last word keeps streaming
  task automatic read(input logic [7:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    rd_addr = a;
    @(negedge ref_clk);
    d = rd_data;
  endtask

  task automatic strobe(input logic take, input logic clr);
    @(negedge ref_clk);
    rx_block_taken = take;
    lost_clear = clr;
    @(negedge ref_clk);
    rx_block_taken = 1'b0;
    lost_clear = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/test_serial_port_status_and_cfg_check.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_port_status_and_cfg_check import spsc_pkg::*;;
  localparam logic [8:0] RXC = 9'h001, RXB = 9'h002, TXS = 9'h004, RTS = 9'h008;
  localparam logic [8:0] EXP = 9'h010, TXC = 9'h020, GAP = 9'h040, LST = 9'h080, REL = 9'h100;
  logic ref_clk, rstn, cfg_load, msg_delay_on, rx_block_taken, lost_clear, rx_drop, m_lost;
  logic use_term_string, use_packet_len, use_rx_timeout, use_char_delay;
  logic [15:0] term_type, handshake, term_count, packet_len, rx_timeout, char_delay;
  logic [15:0] wr_timeout, rd_data, eff_term_type, eff_wr_timeout, lfsr, r1;
  logic [3:0] baud_code, char_width, eff_baud, eff_char_width;
  logic [2:0] parity, eff_parity;
  logic [1:0] stop_bits, eff_stop_bits, eff_handshake;
  logic [8:0] ev;
  logic [7:0] rd_addr;
  logic [10:0] m_cfg;
  logic [15:0] pk [4] = '{16'h0000, 16'h0001, 16'h1000, 16'h1001};
  int m [6];
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  spsc_port_status DUT (
    .ref_clk(ref_clk), .rstn(rstn), .cfg_load(cfg_load), .term_type(term_type),
    .baud_code(baud_code), .parity(parity), .char_width(char_width), .stop_bits(stop_bits),
    .handshake(handshake), .term_count(term_count), .packet_len(packet_len),
    .rx_timeout(rx_timeout), .char_delay(char_delay), .wr_timeout(wr_timeout),
    .rx_char(ev[0]), .rx_block_done(ev[1]), .rx_block_taken(rx_block_taken),
    .tx_start(ev[2]), .tx_rts_ok(ev[3]), .tx_rts_expired(ev[4]), .tx_char(ev[5]),
    .tx_char_gap(ev[6]), .tx_last_char(ev[7]), .tx_rts_released(ev[8]),
    .msg_delay_on(msg_delay_on), .rd_addr(rd_addr), .lost_clear(lost_clear),
    .rd_data(rd_data), .eff_term_type(eff_term_type), .eff_baud(eff_baud),
    .eff_parity(eff_parity), .eff_char_width(eff_char_width), .eff_stop_bits(eff_stop_bits),
    .eff_handshake(eff_handshake), .use_term_string(use_term_string),
    .use_packet_len(use_packet_len), .use_rx_timeout(use_rx_timeout),
    .use_char_delay(use_char_delay), .eff_wr_timeout(eff_wr_timeout), .rx_drop(rx_drop));
  spsc_host_model host (.ref_clk(ref_clk), .rd_data(rd_data), .rd_addr(rd_addr),
    .rx_block_taken(rx_block_taken), .lost_clear(lost_clear));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // the whole run needs about 360 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      test_done();
    end
  end

  // ----------------------------------------
  // stimulus helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic apply(input logic [15:0] tt, input logic [3:0] bc, input logic [2:0] pa,
    input logic [3:0] cw, input logic [1:0] sb, input logic [15:0] hs, tc, pl, rt, cd, wt);
    term_type = tt;
    baud_code = bc;
    parity = pa;
    char_width = cw;
    stop_bits = sb;
    handshake = hs;
    term_count = tc;
    packet_len = pl;
    rx_timeout = rt;
    char_delay = cd;
    wr_timeout = wt;
  endtask

  task automatic fire(input logic [8:0] msk);
    @(negedge ref_clk);
    ev = msk;
    @(negedge ref_clk);
    ev = '0;
  endtask

  task automatic check_words();
    logic [15:0] w;
    host.read(8'he3, w);
    chk_word(w, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      host.read(OFF_RX_STATE + 8'(i), w);
      chk_word(w, 16'(m[i]));
    end
    host.read(OFF_FAULTS, w);
    chk_word(w, {m_lost, 4'h0, m_cfg});
  endtask

  task automatic do_reset();
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    m = '{-1, 0, 0, 0, 0, 0};
    m_lost = 1'b0;
    m_cfg = '0;
    chk_word(16'(eff_baud), 16'h0005);
    chk_word(eff_wr_timeout, 16'h1388);
  endtask

  // watches the transmit state word every cycle after one event
  task automatic seq(input logic [8:0] msk, input logic [63:0] e, input int n);
    logic [15:0] w;
    host.read(OFF_TX_STATE, w);
    fire(msk);
    for (int k = 0; k < n; k++) begin
      @(negedge ref_clk);
      chk_word(rd_data, e[63 - 16 * k -: 16]);
    end
  endtask

  task automatic load_cfg();
    logic [15:0] et, w;
    logic [10:0] f;
    @(negedge ref_clk);
    cfg_load = 1'b1;
    @(negedge ref_clk);
    cfg_load = 1'b0;
    f[0] = term_type > 16'h000f;
    et = f[0] ? 16'h0000 : term_type;
    f[1] = baud_code > 4'h9;
    f[2] = parity > 3'h4;
    f[3] = char_width < 4'h5 || char_width > 4'h8;
    f[4] = stop_bits != 2'h1 && stop_bits != 2'h2;
    f[5] = handshake > 16'h0003;
    f[6] = et[0] && (term_count == 16'h0000 || term_count > 16'h000c);
    f[7] = et[1] && (packet_len == 16'h0000 || packet_len > 16'h1000);
    f[8] = rx_timeout == 16'h0000;
    f[9] = char_delay == 16'h0000;
    f[10] = wr_timeout == 16'h0000;
    m_cfg = f;
    chk_word(eff_term_type, et);
    chk_word(16'(eff_baud), f[1] ? 16'h0005 : 16'(baud_code));
    chk_word(16'(eff_parity), f[2] ? 16'h0000 : 16'(parity));
    chk_word(16'(eff_char_width), f[3] ? 16'h0008 : 16'(char_width));
    chk_word(16'(eff_stop_bits), f[4] ? 16'h0001 : 16'(stop_bits));
    chk_word(16'(eff_handshake), f[5] ? 16'h0000 : handshake);
    chk_flag(use_term_string, et[0] && !f[6]);
    chk_flag(use_packet_len, et[1] && !f[7]);
    chk_flag(use_rx_timeout, !f[8]);
    chk_flag(use_char_delay, !f[9]);
    chk_word(eff_wr_timeout, f[10] ? 16'h1388 : wr_timeout);
    host.read(OFF_FAULTS, w);
    chk_word(w, {m_lost, 4'h0, m_cfg});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    cfg_load = 1'b0;
    msg_delay_on = 1'b0;
    ev = '0;
    lfsr = 16'h0022;
    apply('0, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0);
    do_reset();
    check_words();
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      r1 = lfsr_next(lfsr);
      lfsr = lfsr_next(r1);
      apply((i % 8 == 7) ? 16'h0020 : 16'(r1[3:0]), r1[7:4], r1[10:8], r1[14:11], lfsr[1:0],
        16'(lfsr[4:2]), 16'(lfsr[8:5]), pk[lfsr[10:9]], lfsr[11] ? 16'h0000 : 16'h0064,
        lfsr[12] ? 16'h0000 : 16'h0005, lfsr[13] ? 16'h0000 : 16'h03e8);
      load_cfg();
    end
    apply(16'h0003, 4'h2, 3'h1, 4'h7, 2'h2, 16'h0001, 16'h0002, 16'h0040, 16'h0064,
      16'h0005, 16'h03e8);
    load_cfg();
    $display("test config done");
    fire(RXC);
    fire(RXC);
    fire(RXB);
    m[0] = 2;
    m[1] = 2;
    m[2] = 1;
    check_words();
    // a character while the block waits is lost and not counted
    fire(RXC);
    chk_flag(rx_drop, 1'b1);
    m_lost = 1'b1;
    check_words();
    host.strobe(1'b0, 1'b1);
    host.strobe(1'b1, 1'b0);
    m_lost = 1'b0;
    m[0] = -1;
    check_words();
    $display("test receive done");
    fire(TXS);
    m[3] = 1;
    check_words();
    seq(EXP, {16'h0002, 16'h0000, 32'h0}, 2);
    fire(TXS);
    fire(RTS);
    fire(TXC);
    seq(TXC | GAP, {16'h001e, 16'h001f, 16'h0020, 16'h0003}, 4);
    fire(TXC | LST);
    m[3] = 4;
    m[4] = 3;
    m[5] = 1;
    check_words();
    seq(REL, {16'h0005, 16'h0000, 32'h0}, 2);
    m[3] = 0;
    check_words();
    msg_delay_on = 1'b1;
    seq(TXS, {16'h0064, 16'h0065, 32'h0}, 2);
    $display("test transmit done");
    msg_delay_on = 1'b0;
    do_reset();
    check_words();
    $display("test second reset done");
    test_done();
  end
endmodule
`default_nettype wire
